/* File: inc/ovp_defines.svh */
// Purpose: offsets, field positions, reset values and counts of the overvoltage stage
// Assumes: byte addresses on an 8-bit register port
// Notes:   included by bare name
`ifndef OVP_DEFINES_SVH
`define OVP_DEFINES_SVH
`define OVP_ADDR_W      8
`define OVP_CTRL        8'h00
`define OVP_VT_PRIM     8'h04
`define OVP_DELAY       8'h08
`define OVP_STATUS      8'h0C
`define OVP_EVT         8'h10
`define OVP_MASK        8'h14
`define OVP_RATIO_A     8'h18
`define OVP_RATIO_B     8'h1C
`define OVP_RATIO_C     8'h20
`define OVP_RATIO_M     8'h24
`define OVP_PRIMARY     8'h28
`define OVP_EXP_TIME    8'h2C
`define OVP_REM_TIME    8'h30
`define OVP_GRP_BASE    8'h40
`define OVP_CTRL_FEN    0
`define OVP_CTRL_FSEL   2:1
`define OVP_GRP_USET    15:0
`define OVP_GRP_MODE    17:16
`define OVP_GRP_RST     18'h0_2904
`define OVP_VT_RST      24'h00_0000
`define OVP_DELAY_RST   19'h0_0008
`define OVP_HYST_PCT    24'h00_0061
`define OVP_FULL_PCT    24'h00_0064
`define OVP_FULL_SCALE  16'h2710
`define OVP_TICK_MS     5
`endif

/* File: inc/ovp_pkg.sv */
// Purpose: types shared by the overvoltage stage
// Assumes: nothing
// Notes:   status codes are one-hot
package ovp_pkg;
   typedef enum logic [3:0] {
      ST_NORMAL  = 4'b0001,
      ST_START   = 4'b0010,
      ST_TRIP    = 4'b0100,
      ST_BLOCKED = 4'b1000
   } stage_status_t;
   typedef enum logic [1:0] {
      MODE_ONE   = 2'b00,
      MODE_TWO   = 2'b01,
      MODE_THREE = 2'b10
   } op_mode_t;
endpackage : ovp_pkg

/* File: rtl/group_store.sv */
// Purpose: setting-group memory, one word per group
// Assumes: one write port, one registered read port
// Notes:   every word resets to the default pick-up settings
`timescale 1ns/10ps
`default_nettype none
`include "ovp_defines.svh"
module group_store #(
   parameter int GROUPS = 4,
   parameter int WW     = 18
) (
   input  wire logic                      clk_sys_i,
   input  wire logic                      rst_n_i,
   input  wire logic                      we_i,
   input  wire logic [$clog2(GROUPS)-1:0] waddr_i,
   input  wire logic [WW-1:0]             wdata_i,
   input  wire logic [$clog2(GROUPS)-1:0] raddr_i,
   output logic [WW-1:0]                  rdata_o
);
   logic [WW-1:0] mem_q [GROUPS];

   for (genvar g = 0; g < GROUPS; g++) begin : g_word
      always_ff @(posedge clk_sys_i) begin
         if (!rst_n_i) begin
            mem_q[g] <= WW'(`OVP_GRP_RST);
         end else if (we_i && (waddr_i == g)) begin
            mem_q[g] <= wdata_i;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         rdata_o <= WW'(`OVP_GRP_RST);
      end else begin
         rdata_o <= mem_q[raddr_i];
      end
   end
endmodule : group_store
`default_nettype wire

/* File: rtl/overvoltage_pickup_stage.sv */
// Purpose: pick-up, blocking, forcing and info values of one overvoltage stage
// Assumes: magnitudes in 0.01 %Un, one valid strobe per 5 ms program cycle
// Notes:   definite-time countdown only, release timing kept outside
//
// How it works
// - forced status overrides start, trip and blocked outputs when forcing enabled, pickup_o not
// - general settings ignore setting-group changes
// - per-voltage ratio of magnitude to threshold
// - one threshold shared by all three voltages
// - pick-up when enough voltages exceed threshold
// - picked voltage restores below 97 percent
// - threshold in 0.01 %Un, default 105 %
// - group change swaps settings while running
// - expected operating time readable, 5 ms steps
// - remaining time to trip counts down
// - ratio values per phase and overall
// - threshold reported in primary 0.1 V
// - blocking sampled per cycle, gives blocked during pick-up
// - inputs are 5 ms fundamental magnitudes
`timescale 1ns/10ps
`default_nettype none
`include "ovp_defines.svh"
module overvoltage_pickup_stage #(
   parameter int GROUPS = 4,
   parameter int TW     = 19
) (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic [31:0]      reg_rdata_o,
   input  wire logic        meas_valid_i,
   input  wire logic [15:0] meas_a_i,
   input  wire logic [15:0] meas_b_i,
   input  wire logic [15:0] meas_c_i,
   input  wire logic        block_i,
   input  wire logic [1:0]  group_sel_i,
   output logic            pickup_o,
   output logic            start_o,
   output logic            trip_o,
   output logic            blocked_o,
   output logic            irq_o
);
   import ovp_pkg::*;
   localparam int GW = $clog2(GROUPS);

   function automatic stage_status_t sel2stat(input logic [1:0] s);
      case (s)
         2'b00:   sel2stat = ST_NORMAL;
         2'b01:   sel2stat = ST_START;
         2'b10:   sel2stat = ST_TRIP;
         default: sel2stat = ST_BLOCKED;
      endcase
   endfunction : sel2stat

   function automatic logic [1:0] vcount(input logic [2:0] f);
      vcount = {1'b0, f[0]} + {1'b0, f[1]} + {1'b0, f[2]};
   endfunction : vcount

   ////////////////////////////////////////////////////////////////////
   // register state
   logic          force_en_q;
   logic [1:0]    force_sel_q;
   logic [23:0]   vt_prim_q;
   logic [TW-1:0] delay_q;
   logic [2:0]    evt_q;
   logic [2:0]    mask_q;
   logic [2:0]    evt_set;
   logic          wr_grp;
   logic [17:0]   grp_word;
   logic [15:0]   uset;
   logic [1:0]    need;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         force_en_q  <= 1'b0;
         force_sel_q <= 2'b00;
         vt_prim_q   <= `OVP_VT_RST;
         delay_q     <= TW'(`OVP_DELAY_RST);
         mask_q      <= 3'h0;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            `OVP_CTRL: begin
               force_en_q  <= reg_wdata_i[`OVP_CTRL_FEN];
               force_sel_q <= reg_wdata_i[`OVP_CTRL_FSEL];
            end
            `OVP_VT_PRIM: vt_prim_q <= reg_wdata_i[23:0];
            `OVP_DELAY:   delay_q   <= reg_wdata_i[TW-1:0];
            `OVP_MASK:    mask_q    <= reg_wdata_i[2:0];
            default: ;
         endcase
      end
   end

   assign wr_grp = reg_wr_i && (reg_addr_i[7:6] == 2'(`OVP_GRP_BASE >> 6))
                   && (reg_addr_i[5:2] < 4'(GROUPS)) && (reg_addr_i[1:0] == 2'b00);

   group_store #(.GROUPS(GROUPS), .WW(18)) u_groups (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .we_i      (wr_grp),
      .waddr_i   (reg_addr_i[GW+1:2]),
      .wdata_i   (reg_wdata_i[17:0]),
      .raddr_i   (group_sel_i[GW-1:0]),
      .rdata_o   (grp_word)
   );

   assign uset = grp_word[`OVP_GRP_USET];
   always_comb begin
      case (op_mode_t'(grp_word[`OVP_GRP_MODE]))
         MODE_ONE: need = 2'd1;
         MODE_TWO: need = 2'd2;
         default:  need = 2'd3;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // per-voltage pick-up flags with hysteresis
   logic [15:0] mag_q [3];
   logic [15:0] mag_in [3];
   logic [15:0] mag_max;
   logic [2:0]  flag_q;
   logic        blk_q;
   logic        eval_q;
   logic [23:0] drop_lvl;

   assign mag_in[0] = meas_a_i;
   assign mag_in[1] = meas_b_i;
   assign mag_in[2] = meas_c_i;
   assign drop_lvl = 24'(uset) * `OVP_HYST_PCT;

   for (genvar i = 0; i < 3; i++) begin : g_phase
      always_ff @(posedge clk_sys_i) begin
         if (!rst_n_i) begin
            flag_q[i] <= 1'b0;
            mag_q[i]  <= 16'h0000;
         end else if (meas_valid_i) begin
            mag_q[i] <= mag_in[i];
            if (mag_in[i] > uset) begin
               flag_q[i] <= 1'b1;
            end else if (24'(mag_in[i]) * `OVP_FULL_PCT < drop_lvl) begin
               flag_q[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         blk_q  <= 1'b0;
         eval_q <= 1'b0;
      end else begin
         eval_q <= meas_valid_i;
         if (meas_valid_i) begin
            blk_q <= block_i;
         end
      end
   end

   assign mag_max = (mag_q[0] > mag_q[1]) ?
                    ((mag_q[0] > mag_q[2]) ? mag_q[0] : mag_q[2]) :
                    ((mag_q[1] > mag_q[2]) ? mag_q[1] : mag_q[2]);

   ////////////////////////////////////////////////////////////////////
   // stage status and definite-time countdown
   stage_status_t real_q;
   stage_status_t shown_q;
   stage_status_t forced;
   logic          pick;
   logic [TW-1:0] rem_q;

   assign pick   = vcount(flag_q) >= need;
   assign forced = sel2stat(force_sel_q);

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         real_q <= ST_NORMAL;
         rem_q  <= TW'(`OVP_DELAY_RST);
      end else if (eval_q) begin
         if (!pick) begin
            real_q <= ST_NORMAL;
            rem_q  <= delay_q;
         end else if (blk_q) begin
            real_q <= ST_BLOCKED;
            rem_q  <= delay_q;
         end else begin
            case (real_q)
               ST_TRIP: real_q <= ST_TRIP;
               ST_START: begin
                  if (rem_q <= TW'(1)) begin
                     real_q <= ST_TRIP;
                     rem_q  <= '0;
                  end else begin
                     rem_q <= rem_q - TW'(1);
                  end
               end
               default: begin
                  real_q <= (delay_q == '0) ? ST_TRIP : ST_START;
                  rem_q  <= delay_q;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         shown_q   <= ST_NORMAL;
         pickup_o  <= 1'b0;
         start_o   <= 1'b0;
         trip_o    <= 1'b0;
         blocked_o <= 1'b0;
      end else begin
         shown_q   <= force_en_q ? forced : real_q;
         pickup_o  <= pick;
         start_o   <= (shown_q == ST_START) || (shown_q == ST_TRIP);
         trip_o    <= (shown_q == ST_TRIP);
         blocked_o <= (shown_q == ST_BLOCKED);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // events and interrupt
   assign evt_set = {(shown_q == ST_BLOCKED) && !blocked_o,
                     (shown_q == ST_TRIP) && !trip_o,
                     (shown_q == ST_START) && !start_o};

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         evt_q <= 3'h0;
         irq_o <= 1'b0;
      end else begin
         if (reg_wr_i && (reg_addr_i == `OVP_EVT)) begin
            evt_q <= (evt_q & ~reg_wdata_i[2:0]) | evt_set;
         end else begin
            evt_q <= evt_q | evt_set;
         end
         irq_o <= |(evt_q & mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // ratio and primary-volt sequencer
   logic [2:0]  idx_q;
   logic        seq_run_q;
   logic        kick_q;
   logic        div_busy;
   logic        div_done;
   logic [39:0] div_num;
   logic [15:0] div_den;
   logic [39:0] div_quot;
   logic [15:0] ratio_q [4];
   logic [31:0] prim_q;

   always_comb begin
      div_den = uset;
      case (idx_q)
         3'd0, 3'd1, 3'd2: div_num = 40'(mag_q[idx_q[1:0]]) * 40'd100;
         3'd3:             div_num = 40'(mag_max) * 40'd100;
         default: begin
            div_num = 40'(uset) * 40'(vt_prim_q);
            div_den = `OVP_FULL_SCALE;
         end
      endcase
   end

   ratio_divider #(.NW(40), .DW(16)) u_div (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .start_i   (kick_q),
      .num_i     (div_num),
      .den_i     (div_den),
      .busy_o    (div_busy),
      .done_o    (div_done),
      .quot_o    (div_quot)
   );

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         idx_q     <= 3'd0;
         seq_run_q <= 1'b0;
         kick_q    <= 1'b0;
         prim_q    <= 32'h0000_0000;
         for (int k = 0; k < 4; k++) begin
            ratio_q[k] <= 16'h0000;
         end
      end else if (eval_q) begin
         idx_q     <= 3'd0;
         seq_run_q <= 1'b1;
         kick_q    <= 1'b1;
      end else begin
         kick_q <= 1'b0;
         if (seq_run_q && div_done) begin
            if (idx_q == 3'd4) begin
               prim_q    <= div_quot[31:0];
               seq_run_q <= 1'b0;
            end else begin
               ratio_q[idx_q[1:0]] <= div_quot[15:0];
               idx_q  <= idx_q + 3'd1;
               kick_q <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // register read
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `OVP_CTRL:     reg_rdata_o <= {29'h0, force_sel_q, force_en_q};
            `OVP_VT_PRIM:  reg_rdata_o <= {8'h00, vt_prim_q};
            `OVP_DELAY:    reg_rdata_o <= 32'(delay_q);
            `OVP_STATUS:   reg_rdata_o <= {22'h0, pick, blk_q, 1'b0, flag_q, shown_q};
            `OVP_EVT:      reg_rdata_o <= {29'h0, evt_q};
            `OVP_MASK:     reg_rdata_o <= {29'h0, mask_q};
            `OVP_RATIO_A:  reg_rdata_o <= {16'h0, ratio_q[0]};
            `OVP_RATIO_B:  reg_rdata_o <= {16'h0, ratio_q[1]};
            `OVP_RATIO_C:  reg_rdata_o <= {16'h0, ratio_q[2]};
            `OVP_RATIO_M:  reg_rdata_o <= {16'h0, ratio_q[3]};
            `OVP_PRIMARY:  reg_rdata_o <= prim_q;
            `OVP_EXP_TIME: reg_rdata_o <= 32'(delay_q);
            `OVP_REM_TIME: reg_rdata_o <= 32'(rem_q);
            default:       reg_rdata_o <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata_o <= 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   a_force_override: assert property (
      force_en_q |=> shown_q == $past(forced) ##1 trip_o == ($past(forced, 2) == ST_TRIP))
      else $error("forced status not shown");
   a_group_static: assert property (
      !reg_wr_i && (group_sel_i != $past(group_sel_i)) |=> $stable(force_en_q) && $stable(delay_q))
      else $error("general setting moved with group");
   a_flag_sets: assert property (
      meas_valid_i && (meas_a_i > uset) |=> flag_q[0])
      else $error("flag did not set above threshold");
   a_hyst_holds: assert property (
      meas_valid_i && flag_q[1] && (24'(meas_b_i) * `OVP_FULL_PCT >= drop_lvl) |=> flag_q[1])
      else $error("flag dropped inside hysteresis band");
   a_flags_steady: assert property (
      !meas_valid_i |=> $stable(flag_q))
      else $error("flags moved without a sample");
   a_block_wins: assert property (
      eval_q && pick && blk_q |=> real_q == ST_BLOCKED)
      else $error("blocked pick-up not reported as blocked");
   a_rem_counts: assert property (
      eval_q && pick && !blk_q && real_q == ST_START && rem_q > TW'(1)
      |=> rem_q == $past(rem_q) - TW'(1))
      else $error("countdown step wrong");
   a_ratio_ends: assert property (
      eval_q |=> seq_run_q ##[1:300] !seq_run_q)
      else $error("ratio sequence too slow");
   a_irq_level: assert property (
      |(evt_q & mask_q) |=> irq_o)
      else $error("interrupt missing");

   c_trip: cover property (eval_q && real_q == ST_START ##1 real_q == ST_TRIP);
   c_blocked: cover property (blocked_o);
   c_forced: cover property (force_en_q ##2 trip_o);
endmodule : overvoltage_pickup_stage
`default_nettype wire

/* File: rtl/ratio_divider.sv */
// Purpose: restoring unsigned divider, one quotient bit per clock
// Assumes: start is ignored while busy
// Notes:   quotient and done come from flops
`timescale 1ns/10ps
`default_nettype none
module ratio_divider #(
   parameter int NW = 40,
   parameter int DW = 16
) (
   input  wire logic          clk_sys_i,
   input  wire logic          rst_n_i,
   input  wire logic          start_i,
   input  wire logic [NW-1:0] num_i,
   input  wire logic [DW-1:0] den_i,
   output logic               busy_o,
   output logic               done_o,
   output logic [NW-1:0]      quot_o
);
   localparam int CW = $clog2(NW + 1);
   logic [DW-1:0] r_q;
   logic [DW-1:0] d_q;
   logic [CW-1:0] cnt_q;
   logic [DW+1:0] trial;

   assign trial = {1'b0, r_q, quot_o[NW-1]} - {2'b00, d_q};

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         quot_o <= '0;
         r_q    <= '0;
         d_q    <= '0;
         cnt_q  <= '0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else if (start_i && !busy_o) begin
         quot_o <= num_i;
         d_q    <= den_i;
         r_q    <= '0;
         cnt_q  <= CW'(NW);
         busy_o <= 1'b1;
         done_o <= 1'b0;
      end else if (busy_o) begin
         if (!trial[DW+1]) begin
            r_q    <= trial[DW-1:0];
            quot_o <= {quot_o[NW-2:0], 1'b1};
         end else begin
            r_q    <= {r_q[DW-2:0], quot_o[NW-1]};
            quot_o <= {quot_o[NW-2:0], 1'b0};
         end
         cnt_q  <= cnt_q - CW'(1);
         busy_o <= (cnt_q != CW'(1));
         done_o <= (cnt_q == CW'(1));
      end else begin
         done_o <= 1'b0;
      end
   end
endmodule : ratio_divider
`default_nettype wire

/* File: verif/meas_source.sv */
// Purpose: model of the measurement channels and the blocking matrix
// Assumes: one strobe every PERIOD clocks stands for one 5 ms program cycle
// Notes:   magnitudes are only valid with the strobe, inverted otherwise
`timescale 1ns/10ps
`default_nettype none
module meas_source #(
   parameter int PERIOD = 400
) (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic [15:0] mag_a_i,
   input  wire logic [15:0] mag_b_i,
   input  wire logic [15:0] mag_c_i,
   input  wire logic        block_req_i,
   output logic             meas_valid_o,
   output logic [15:0]      meas_a_o,
   output logic [15:0]      meas_b_o,
   output logic [15:0]      meas_c_o,
   output logic             block_o
);
   logic [15:0] cnt_q;
   logic        fire;
   assign fire = (cnt_q == 16'(PERIOD - 1));
   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         cnt_q        <= 16'h0000;
         meas_valid_o <= 1'b0;
      end else begin
         cnt_q        <= fire ? 16'h0000 : cnt_q + 16'h0001;
         meas_valid_o <= fire;
      end
   end
   // stale data never looks valid between strobes
   always_ff @(posedge clk_sys_i) begin
      meas_a_o <= fire ? mag_a_i : ~mag_a_i;
      meas_b_o <= fire ? mag_b_i : ~mag_b_i;
      meas_c_o <= fire ? mag_c_i : ~mag_c_i;
   end
   always_ff @(posedge clk_sys_i) begin
      block_o <= rst_n_i & block_req_i;
   end
endmodule : meas_source
`default_nettype wire

/* File: verif/tb.sv */
// Purpose: self-checking bench of the overvoltage pick-up stage
// Assumes: register port with read data one cycle after the strobe
// Notes:   one sample is one strobe of the measurement model
`timescale 1ns/10ps
`default_nettype none
`include "ovp_defines.svh"
`define CHK(got, exp) \
   begin \
      check_count++; \
      if ((got) !== (exp)) begin \
         fails++; \
         $display("mismatch t=%0t got %h exp %h", $time, (got), (exp)); \
      end \
   end
module tb;
   localparam logic [15:0] HI = 16'h2968;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   logic        clk_sys_i, rst_n_i, reg_wr, reg_rd, meas_valid, block, block_req;
   logic        pickup, start, trip, blocked, irq;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [15:0] meas_a, meas_b, meas_c, mag_a, mag_b, mag_c;
   logic [1:0]  group_sel;
   int          fails, check_count, cycles;
   ////////////////////////////////////////////////////////////////////////////
   overvoltage_pickup_stage #(.GROUPS(4), .TW(19)) u_overvoltage_pickup_stage (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr),
      .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
      .reg_rdata_o(reg_rdata), .meas_valid_i(meas_valid), .meas_a_i(meas_a),
      .meas_b_i(meas_b), .meas_c_i(meas_c), .block_i(block), .group_sel_i(group_sel),
      .pickup_o(pickup), .start_o(start), .trip_o(trip), .blocked_o(blocked),
      .irq_o(irq));
   meas_source #(.PERIOD(400)) u_meas_source (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .mag_a_i(mag_a), .mag_b_i(mag_b),
      .mag_c_i(mag_c), .block_req_i(block_req), .meas_valid_o(meas_valid),
      .meas_a_o(meas_a), .meas_b_o(meas_b), .meas_c_o(meas_c), .block_o(block));
   ////////////////////////////////////////////////////////////////////////////
   always #25 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         end_sim();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr <= 1'b0;
      @(posedge clk_sys_i);
   endtask : reg_write
   // read data is looked at in the one cycle it stands
   task automatic reg_read(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd <= 1'b0;
      @(posedge clk_sys_i);
      `CHK(reg_rdata & m, e)
   endtask : reg_read
   // wait for one strobe, then for the ratios to settle
   task automatic sample(input logic [15:0] a, b, c, input logic blk);
      int n;
      mag_a     <= a;
      mag_b     <= b;
      mag_c     <= c;
      block_req <= blk;
      n = 0;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (meas_valid !== 1'b1 && n < 800);
      repeat (250) @(posedge clk_sys_i);
   endtask : sample
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys_i = 1'b0;
      rst_n_i   = 1'b0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 32'h0000_0000;
      group_sel = 2'h0;
      block_req = 1'b0;
      {mag_a, mag_b, mag_c} = 48'h0000_0000_0000;
      fails = 0;
      check_count = 0;
      cycles = 0;
      repeat (2) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      // reset values and an unmapped place
      reg_read(`OVP_CTRL, 32'h0000_0000, ALL);
      reg_read(`OVP_DELAY, 32'h0000_0008, ALL);
      reg_read(`OVP_EXP_TIME, 32'h0000_0008, ALL);
      reg_read(`OVP_STATUS, 32'h0000_0001, ALL);
      reg_read(`OVP_EVT, 32'h0000_0000, ALL);
      reg_write(8'h3C, 32'h0000_ABCD);
      reg_read(8'h3C, 32'h0000_0000, ALL);
      reg_write(`OVP_VT_PRIM, 32'h0000_2710);
      reg_write(`OVP_DELAY, 32'h0000_0002);
      reg_read(`OVP_EXP_TIME, 32'h0000_0002, ALL);
      // ratios below threshold
      sample(16'h2710, 16'h1482, 16'h20D0, 1'b0);
      reg_read(`OVP_RATIO_A, 32'h0000_005F, ALL);
      reg_read(`OVP_RATIO_B, 32'h0000_0032, ALL);
      reg_read(`OVP_RATIO_C, 32'h0000_0050, ALL);
      reg_read(`OVP_RATIO_M, 32'h0000_005F, ALL);
      reg_read(`OVP_PRIMARY, 32'h0000_2904, ALL);
      `CHK(pickup, 1'b0);
      // one voltage over, countdown, trip, hysteresis boundary
      sample(HI, 16'h0000, 16'h0000, 1'b0);
      `CHK(start, 1'b1);
      reg_read(`OVP_STATUS, 32'h0000_0212, ALL);
      reg_read(`OVP_REM_TIME, 32'h0000_0002, ALL);
      reg_read(`OVP_RATIO_A, 32'h0000_0064, ALL);
      reg_read(`OVP_EVT, 32'h0000_0001, ALL);
      reg_write(`OVP_MASK, 32'h0000_0001);
      repeat (2) @(posedge clk_sys_i);
      `CHK(irq, 1'b1);
      reg_write(`OVP_EVT, 32'h0000_0001);
      repeat (2) @(posedge clk_sys_i);
      `CHK(irq, 1'b0);
      sample(HI, 16'h0000, 16'h0000, 1'b0);
      reg_read(`OVP_REM_TIME, 32'h0000_0001, ALL);
      sample(16'h283C, 16'h0000, 16'h0000, 1'b0);
      `CHK(trip, 1'b1);
      reg_read(`OVP_STATUS, 32'h0000_0214, ALL);
      reg_read(`OVP_EVT, 32'h0000_0002, ALL);
      sample(16'h27C9, 16'h0000, 16'h0000, 1'b0);
      `CHK(pickup, 1'b1);
      sample(16'h27C8, 16'h0000, 16'h0000, 1'b0);
      `CHK(pickup, 1'b0);
      reg_read(`OVP_STATUS, 32'h0000_0001, ALL);
      reg_write(`OVP_EVT, 32'h0000_0007);
      // every operation mode, one voltage short then enough
      for (int m = 0; m < 4; m++) begin
         reg_write(`OVP_GRP_BASE, {14'h0000, m[1:0], 16'h2904});
         sample(m >= 1 ? HI : 16'h0000, m >= 2 ? HI : 16'h0000, 16'h0000, 1'b0);
         `CHK(pickup, 1'b0);
         sample(HI, m >= 1 ? HI : 16'h0000, m >= 2 ? HI : 16'h0000, 1'b0);
         `CHK(pickup, 1'b1);
         sample(16'h0000, 16'h0000, 16'h0000, 1'b0);
      end
      // blocking during pick-up
      reg_write(`OVP_GRP_BASE, 32'h0000_2904);
      sample(HI, 16'h0000, 16'h0000, 1'b1);
      `CHK(blocked, 1'b1);
      `CHK(start, 1'b0);
      reg_read(`OVP_STATUS, 32'h0000_0318, ALL);
      reg_read(`OVP_EVT, 32'h0000_0004, 32'h0000_0004);
      sample(16'h0000, 16'h0000, 16'h0000, 1'b0);
      // setting-group change while running
      reg_write(`OVP_GRP_BASE + 8'h04, 32'h0000_2710);
      group_sel <= 2'h1;
      sample(16'h0000, 16'h2774, 16'h0000, 1'b0);
      `CHK(pickup, 1'b1);
      reg_read(`OVP_RATIO_B, 32'h0000_0065, ALL);
      reg_read(`OVP_PRIMARY, 32'h0000_2710, ALL);
      group_sel <= 2'h0;
      sample(16'h0000, 16'h2774, 16'h0000, 1'b0);
      `CHK(pickup, 1'b0);
      // forced status, unmoved by group changes
      for (int s = 0; s < 4; s++) begin
         group_sel <= {1'b0, s[0]};
         reg_write(`OVP_CTRL, {29'h0000_0000, s[1:0], 1'b1});
         repeat (4) @(posedge clk_sys_i);
         `CHK(start, (s == 1 || s == 2));
         `CHK(trip, (s == 2));
         `CHK(blocked, (s == 3));
         reg_read(`OVP_STATUS, 32'h0000_0001 << s, 32'h0000_000F);
      end
      group_sel <= 2'h0;
      reg_write(`OVP_CTRL, 32'h0000_0004);
      repeat (4) @(posedge clk_sys_i);
      `CHK(trip, 1'b0);
      reg_read(`OVP_STATUS, 32'h0000_0001, 32'h0000_000F);
      end_sim();
   end
endmodule : tb
`default_nettype wire
